// ===== pkg/run_stop_pkg.sv
package run_stop_pkg;

  localparam int unsigned CLK_PERIOD_PS  = 5000;
  localparam int unsigned DIAG_TIME_NS   = 10000;
  localparam int unsigned DIAG_CYCLES    = (DIAG_TIME_NS * 1000 + CLK_PERIOD_PS - 1)
                                           / CLK_PERIOD_PS;
  localparam int unsigned DIAG_CNT_W     = 11;
  localparam logic [DIAG_CNT_W-1:0] DIAG_LAST = DIAG_CNT_W'(DIAG_CYCLES - 1);
  localparam logic [DIAG_CNT_W-1:0] DIAG_CNT_RST = 11'h000;

  localparam longint unsigned FLASH_HALF_MS    = 64'd250;
  localparam longint unsigned FLASH_HALF_CYC_L = FLASH_HALF_MS * 64'd1000000000
                                                 / CLK_PERIOD_PS;
  localparam int unsigned FLASH_CNT_W = 32;
  localparam logic [FLASH_CNT_W-1:0] FLASH_HALF_CYCLES_DEF = FLASH_HALF_CYC_L[31:0];
  localparam logic [FLASH_CNT_W-1:0] FLASH_CNT_RST = 32'h0000_0000;

  // Inputs first_general_input to last_general_input, octal numbering.
  localparam int unsigned GEN_INPUTS_DEF = 16;
  localparam int unsigned SEL_W          = 4;
  localparam int unsigned DATA_W_DEF     = 16;

  typedef enum logic [1:0] {
    ST_DIAG  = 2'h0,
    ST_OPER  = 2'h1,
    ST_FAULT = 2'h2
  } diag_state_e;

  typedef enum logic [1:0] {
    OVR_NONE = 2'h0,
    OVR_RUN  = 2'h1,
    OVR_STOP = 2'h2
  } ovr_e;

  typedef enum logic [1:0] {
    OP_FORCE_ON    = 2'h0,
    OP_FORCE_OFF   = 2'h1,
    OP_SET_CURRENT = 2'h2,
    OP_SET_SETTING = 2'h3
  } op_e;

  typedef enum logic [3:0] {
    CLS_INPUT     = 4'h0,
    CLS_OUTPUT    = 4'h1,
    CLS_AUX       = 4'h2,
    CLS_STATE     = 4'h3,
    CLS_TIMER     = 4'h4,
    CLS_COUNTER   = 4'h5,
    CLS_DATA      = 4'h6,
    CLS_EXT_FILE  = 4'h7,
    CLS_FILE_PROG = 4'h8,
    CLS_OTHER_REG = 4'h9
  } dev_class_e;

  localparam diag_state_e DIAG_RST = ST_DIAG;
  localparam ovr_e        OVR_RST  = OVR_NONE;

endpackage

// ===== rtl/latest_value_hold.sv
`timescale 1ns/1ps
module latest_value_hold
  import run_stop_pkg::*;
#(
  parameter int unsigned W = DATA_W_DEF
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic         clk_en,
  input  wire logic         tool_wr,
  input  wire logic [W-1:0] tool_data,
  input  wire logic         prog_wr,
  input  wire logic [W-1:0] prog_data,
  output logic      [W-1:0] value
);

  typedef struct packed {
    logic [W-1:0] value;
  } hold_s;

  hold_s r_reg;
  hold_s r_next;

  // The most recent write wins; a tool write lands after the program write of the same cycle.
  always_comb begin
    r_next = r_reg;
    if (prog_wr) begin
      r_next.value = prog_data;
    end
    if (tool_wr) begin
      r_next.value = tool_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      r_reg <= '0;
    end else if (clk_en) begin
      r_reg <= r_next;
    end
  end

  assign value = r_reg.value;

  AST_TOOL_LATEST: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && tool_wr |=> value == $past(tool_data))
    else $error("tool write not held");
  AST_PROG_LATEST: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && prog_wr && !tool_wr |=> value == $past(prog_data))
    else $error("program write not held");

endmodule

// ===== rtl/run_stop_arbiter_test_access.sv
`timescale 1ns/1ps
module run_stop_arbiter_test_access
  import run_stop_pkg::*;
#(
  parameter int unsigned               GEN_INPUTS        = GEN_INPUTS_DEF,
  parameter int unsigned               DATA_W            = DATA_W_DEF,
  parameter logic [FLASH_CNT_W-1:0]    FLASH_HALF_CYCLES = FLASH_HALF_CYCLES_DEF
) (
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  input  wire logic                  clk_en,
  input  wire logic                  mode_switch_run,
  input  wire logic [GEN_INPUTS-1:0] general_inputs,
  input  wire logic                  run_input_en,
  input  wire logic [SEL_W-1:0]      run_input_sel,
  input  wire logic                  tool_run_cmd,
  input  wire logic                  tool_stop_cmd,
  input  wire logic                  diag_hw_ok,
  input  wire logic                  diag_param_ok,
  input  wire logic                  diag_prog_ok,
  input  wire logic                  scan_end,
  input  wire logic                  req_valid,
  input  wire logic [1:0]            req_op,
  input  wire logic [3:0]            req_class,
  input  wire logic                  req_from_display,
  input  wire logic                  req_used_in_prog,
  input  wire logic                  req_driven_by_prog,
  input  wire logic                  mem_in_cassette,
  input  wire logic                  cassette_protect,
  input  wire logic [DATA_W-1:0]     req_data,
  input  wire logic                  prog_wr,
  input  wire logic [DATA_W-1:0]     prog_data,
  output logic                       run_active,
  output logic                       run_led,
  output logic                       fault_led,
  output logic                       req_accept,
  output logic                       req_reject,
  output logic                       force_hold,
  output logic                       force_value,
  output logic                       force_retain,
  output logic                       setting_wr,
  output logic [DATA_W-1:0]          current_value
);

  typedef struct packed {
    diag_state_e            diag;
    logic [DIAG_CNT_W-1:0]  diag_cnt;
    logic [FLASH_CNT_W-1:0] flash_cnt;
    logic                   flash_ph;
    logic                   hw_fault;
    ovr_e                   ovr;
    logic                   local_prev;
    logic                   run;
    logic                   fault_led;
    logic                   accept;
    logic                   reject;
    logic                   setting_wr;
    logic                   force_hold;
    logic                   force_val;
    logic                   force_retain;
    logic                   force_is_input;
  } state_s;

  state_s r_reg;
  state_s r_next;

  logic local_run;
  logic sel_input;
  logic req_ok;
  logic is_force;
  logic tool_value_wr;

  function automatic logic access_ok(input op_e op, input dev_class_e cls,
                                     input logic disp, input logic driven,
                                     input logic cassette, input logic protect);
    logic ok;
    ok = 1'b0;
    case (op)
      OP_FORCE_ON, OP_FORCE_OFF: begin
        ok = (cls <= CLS_COUNTER);
        if (cls == CLS_INPUT && disp) begin
          ok = 1'b0;
        end
        if (op == OP_FORCE_ON && cls == CLS_TIMER && !driven) begin
          ok = 1'b0;
        end
      end
      OP_SET_CURRENT: begin
        ok = (cls >= CLS_TIMER);
        if (cls == CLS_EXT_FILE && !disp) begin
          ok = 1'b0;
        end
        if (cls == CLS_FILE_PROG && disp) begin
          ok = 1'b0;
        end
      end
      OP_SET_SETTING: begin
        ok = (cls == CLS_TIMER || cls == CLS_COUNTER) && driven;
        if (cassette && protect) begin
          ok = 1'b0;
        end
      end
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // Out-of-range selections read as off.
  assign sel_input = (32'(run_input_sel) < GEN_INPUTS) ?
                     general_inputs[run_input_sel] : 1'b0;
  assign local_run = mode_switch_run || (run_input_en && sel_input);
  assign is_force  = (op_e'(req_op) == OP_FORCE_ON) || (op_e'(req_op) == OP_FORCE_OFF);
  assign req_ok    = access_ok(op_e'(req_op), dev_class_e'(req_class), req_from_display,
                               req_driven_by_prog, mem_in_cassette, cassette_protect);
  assign tool_value_wr = clk_en && req_valid && req_ok && (op_e'(req_op) == OP_SET_CURRENT);

  always_comb begin
    r_next            = r_reg;
    r_next.accept     = 1'b0;
    r_next.reject     = 1'b0;
    r_next.setting_wr = 1'b0;
    r_next.local_prev = local_run;

    case (r_reg.diag)
      ST_DIAG: begin
        r_next.diag_cnt = r_reg.diag_cnt + 1'b1;
        if (r_reg.diag_cnt == DIAG_LAST) begin
          if (diag_hw_ok && diag_param_ok && diag_prog_ok) begin
            r_next.diag = ST_OPER;
          end else begin
            r_next.diag     = ST_FAULT;
            r_next.hw_fault = !diag_hw_ok;
          end
        end
      end
      ST_OPER: begin
        r_next.diag = ST_OPER;
      end
      ST_FAULT: begin
        if (r_reg.flash_cnt == FLASH_HALF_CYCLES - 1'b1) begin
          r_next.flash_cnt = FLASH_CNT_RST;
          r_next.flash_ph  = !r_reg.flash_ph;
        end else begin
          r_next.flash_cnt = r_reg.flash_cnt + 1'b1;
        end
      end
      default: begin
        r_next.diag = ST_DIAG;
      end
    endcase

    // A local stop-to-run edge hands control back to the local sources.
    if (local_run && !r_reg.local_prev) begin
      r_next.ovr = OVR_NONE;
    end
    if (tool_run_cmd) begin
      r_next.ovr = OVR_RUN;
    end
    if (tool_stop_cmd) begin
      r_next.ovr = OVR_STOP;
    end

    case (r_next.ovr)
      OVR_RUN:  r_next.run = (r_next.diag == ST_OPER);
      OVR_STOP: r_next.run = 1'b0;
      default:  r_next.run = (r_next.diag == ST_OPER) && r_next.local_prev;
    endcase

    r_next.fault_led = (r_next.diag == ST_FAULT) &&
                       (r_next.hw_fault ? r_next.flash_ph : 1'b1);

    // The input refresh at each scan end overwrites an input force even while stopped.
    if (r_reg.force_hold && scan_end && (!r_reg.force_retain || r_reg.force_is_input)) begin
      r_next.force_hold = 1'b0;
    end

    if (req_valid) begin
      r_next.accept = req_ok;
      r_next.reject = !req_ok;
      if (req_ok && is_force) begin
        r_next.force_hold     = 1'b1;
        r_next.force_val      = (op_e'(req_op) == OP_FORCE_ON);
        r_next.force_is_input = (dev_class_e'(req_class) == CLS_INPUT);
        r_next.force_retain   = (!r_reg.run || !req_used_in_prog) &&
                                (dev_class_e'(req_class) != CLS_INPUT);
      end
      if (req_ok && op_e'(req_op) == OP_SET_SETTING) begin
        r_next.setting_wr = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      r_reg.diag           <= DIAG_RST;
      r_reg.diag_cnt       <= DIAG_CNT_RST;
      r_reg.flash_cnt      <= FLASH_CNT_RST;
      r_reg.flash_ph       <= 1'b0;
      r_reg.hw_fault       <= 1'b0;
      r_reg.ovr            <= OVR_RST;
      r_reg.local_prev     <= 1'b1;
      r_reg.run            <= 1'b0;
      r_reg.fault_led      <= 1'b0;
      r_reg.accept         <= 1'b0;
      r_reg.reject         <= 1'b0;
      r_reg.setting_wr     <= 1'b0;
      r_reg.force_hold     <= 1'b0;
      r_reg.force_val      <= 1'b0;
      r_reg.force_retain   <= 1'b0;
      r_reg.force_is_input <= 1'b0;
    end else if (clk_en) begin
      r_reg <= r_next;
    end
  end

  latest_value_hold #(
    .W (DATA_W)
  ) u_value (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .clk_en    (clk_en),
    .tool_wr   (tool_value_wr),
    .tool_data (req_data),
    .prog_wr   (clk_en && prog_wr),
    .prog_data (prog_data),
    .value     (current_value)
  );

  assign run_active   = r_reg.run;
  assign run_led      = r_reg.run;
  assign fault_led    = r_reg.fault_led;
  assign req_accept   = r_reg.accept;
  assign req_reject   = r_reg.reject;
  assign force_hold   = r_reg.force_hold;
  assign force_value  = r_reg.force_val;
  assign force_retain = r_reg.force_retain;
  assign setting_wr   = r_reg.setting_wr;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  AST_LOCAL_RULES: assert property (
    r_reg.diag == ST_OPER && r_reg.ovr == OVR_NONE |-> run_active == r_reg.local_prev)
    else $error("run state does not follow local sources");
  AST_TOOL_RUN: assert property (
    clk_en && tool_run_cmd && !tool_stop_cmd && r_reg.diag == ST_OPER |=> run_active)
    else $error("tool run did not restart");
  AST_LOCAL_RESTART: assert property (
    clk_en && r_reg.ovr == OVR_STOP && !r_reg.local_prev && local_run && !tool_run_cmd
    && !tool_stop_cmd && r_reg.diag == ST_OPER |=> run_active)
    else $error("local restart failed after tool stop");
  AST_NO_RUN_UNTESTED: assert property (
    r_reg.diag != ST_OPER |-> !run_active && !run_led)
    else $error("running without passed diagnosis");
  AST_FAULT_STEADY: assert property (
    r_reg.diag == ST_FAULT && !r_reg.hw_fault |-> fault_led)
    else $error("fault indicator not lit");
  AST_NO_FAULT_OK: assert property (
    r_reg.diag != ST_FAULT |-> !fault_led)
    else $error("fault indicator lit without fault");
  AST_DISPLAY_INPUT_FORCE: assert property (
    clk_en && req_valid && is_force && req_from_display
    && dev_class_e'(req_class) == CLS_INPUT |=> req_reject && !req_accept)
    else $error("display input force accepted");
  AST_ONE_SCAN: assert property (
    clk_en && force_hold && !force_retain && scan_end && !req_valid |=> !force_hold)
    else $error("force held past one scan");
  AST_TIMER_FORCE: assert property (
    clk_en && req_valid && op_e'(req_op) == OP_FORCE_ON && dev_class_e'(req_class) == CLS_TIMER
    && !req_driven_by_prog |=> req_reject)
    else $error("undriven timer force accepted");
  AST_INPUT_NOT_KEPT: assert property (
    force_hold && r_reg.force_is_input |-> !force_retain)
    else $error("input force retained");
  AST_PROTECT: assert property (
    clk_en && req_valid && op_e'(req_op) == OP_SET_SETTING && mem_in_cassette
    && cassette_protect |=> req_reject && !setting_wr)
    else $error("setting change on locked cassette");
  AST_EXT_FILE: assert property (
    clk_en && req_valid && op_e'(req_op) == OP_SET_CURRENT
    && dev_class_e'(req_class) == CLS_EXT_FILE && !req_from_display |=> req_reject)
    else $error("extension file change from tool");
  AST_PROG_FILE: assert property (
    clk_en && req_valid && op_e'(req_op) == OP_SET_CURRENT
    && dev_class_e'(req_class) == CLS_FILE_PROG && req_from_display |=> req_reject)
    else $error("display changed program-memory file register");
  AST_RESET_OVR: assert property (
    $rose(rst_n) |-> r_reg.ovr == OVR_NONE)
    else $error("override survived reset");

  COV_TOOL_RESTART: cover property (r_reg.ovr == OVR_STOP ##[1:20] r_reg.ovr == OVR_RUN);
  COV_FAULT: cover property (r_reg.diag == ST_FAULT);
  COV_FORCE: cover property (req_accept && force_hold);
  COV_LOCAL_RUN: cover property (r_reg.ovr == OVR_NONE && run_active);

endmodule

// ===== test/tool_cmd_model.sv
`timescale 1ns/1ps
// Far-side command source: the programming tool or the display module.
module tool_cmd_model
  import run_stop_pkg::*;
(
  input  wire logic                  ref_clk,
  output logic                       tool_run_cmd,
  output logic                       tool_stop_cmd,
  output logic                       req_valid,
  output logic [1:0]                 req_op,
  output logic [3:0]                 req_class,
  output logic                       req_from_display,
  output logic [DATA_W_DEF-1:0]      req_data
);
  initial begin
    tool_run_cmd = 1'b0;
    tool_stop_cmd = 1'b0;
    req_valid = 1'b0;
    req_op = 2'h0;
    req_class = 4'h0;
    req_from_display = 1'b0;
    req_data = 16'h0000;
  end

  // A run or stop command is a one-cycle pulse.
  task automatic command(input logic run);
    @(posedge ref_clk);
    tool_run_cmd <= run;
    tool_stop_cmd <= !run;
    @(posedge ref_clk);
    tool_run_cmd <= 1'b0;
    tool_stop_cmd <= 1'b0;
  endtask

  // Outside the request cycle the fields carry inverted values, so nothing may rely on them.
  task automatic request(input op_e op, input dev_class_e cls, input logic disp,
                         input logic [15:0] data);
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_op <= op;
    req_class <= cls;
    req_from_display <= disp;
    req_data <= data;
    @(posedge ref_clk);
    req_valid <= 1'b0;
    req_op <= ~op;
    req_class <= ~cls;
    req_from_display <= ~disp;
    req_data <= ~data;
  endtask
endmodule

// ===== test/testbench.sv
`timescale 1ns/1ps
module testbench
  import run_stop_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst_n, clk_en, mode_switch_run, run_input_en, diag_hw_ok, diag_param_ok, diag_prog_ok;
  logic scan_end, req_used_in_prog, req_driven_by_prog, mem_in_cassette, cassette_protect;
  logic prog_wr;
  logic [15:0] general_inputs, prog_data;
  logic [3:0]  run_input_sel;
  logic tool_run_cmd, tool_stop_cmd, req_valid, req_from_display;
  logic [1:0]  req_op;
  logic [3:0]  req_class;
  logic [15:0] req_data, current_value;
  logic run_active, run_led, fault_led, req_accept, req_reject;
  logic force_hold, force_value, force_retain, setting_wr;
  int   err_count, n_compared, lows;

  always #2.5 ref_clk = ~ref_clk;

  run_stop_arbiter_test_access #(
    .FLASH_HALF_CYCLES(32'h0000_0004)
  ) run_stop_arbiter_test_access_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .mode_switch_run(mode_switch_run),
    .general_inputs(general_inputs), .run_input_en(run_input_en), .run_input_sel(run_input_sel),
    .tool_run_cmd(tool_run_cmd), .tool_stop_cmd(tool_stop_cmd), .diag_hw_ok(diag_hw_ok),
    .diag_param_ok(diag_param_ok), .diag_prog_ok(diag_prog_ok), .scan_end(scan_end),
    .req_valid(req_valid), .req_op(req_op), .req_class(req_class),
    .req_from_display(req_from_display), .req_used_in_prog(req_used_in_prog),
    .req_driven_by_prog(req_driven_by_prog), .mem_in_cassette(mem_in_cassette),
    .cassette_protect(cassette_protect), .req_data(req_data), .prog_wr(prog_wr),
    .prog_data(prog_data), .run_active(run_active), .run_led(run_led),
    .fault_led(fault_led), .req_accept(req_accept), .req_reject(req_reject),
    .force_hold(force_hold), .force_value(force_value), .force_retain(force_retain),
    .setting_wr(setting_wr), .current_value(current_value));

  tool_cmd_model tool_cmd_model_inst (
    .ref_clk(ref_clk), .tool_run_cmd(tool_run_cmd), .tool_stop_cmd(tool_stop_cmd),
    .req_valid(req_valid), .req_op(req_op), .req_class(req_class),
    .req_from_display(req_from_display), .req_data(req_data));

  task automatic chk_bit(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic final_report;
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic wait_on(input logic fault);
    int i;
    for (i = 0; i < 2200; i++) begin
      @(posedge ref_clk);
      #1;
      if ((fault ? fault_led : run_active) === 1'b1) break;
    end
    if (i == 2200) begin
      err_count++;
      $display("Error wait_on expected 1 seen timeout");
      final_report();
    end
  endtask

  task automatic count_low;
    lows = 0;
    repeat (12) begin
      step(1);
      if (fault_led === 1'b0) lows++;
    end
  endtask

  task automatic power_up(input logic hw, input logic par, input logic prg);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    diag_hw_ok <= hw;
    diag_param_ok <= par;
    diag_prog_ok <= prg;
    step(12);
    chk_bit("run_active in reset", 1'b0, run_active);
    chk_bit("fault_led in reset", 1'b0, fault_led);
    @(posedge ref_clk);
    rst_n <= 1'b1;
  endtask

  task automatic pick_input(input logic en, input logic [3:0] sel);
    @(posedge ref_clk);
    run_input_en <= en;
    run_input_sel <= sel;
  endtask

  task automatic prog_write(input logic [15:0] d);
    @(posedge ref_clk);
    prog_wr <= 1'b1;
    prog_data <= d;
    @(posedge ref_clk);
    prog_wr <= 1'b0;
    prog_data <= ~d;
  endtask

  task automatic set_local(input logic sw, input logic inp);
    @(posedge ref_clk);
    mode_switch_run <= sw;
    general_inputs <= {inp, 15'h2aaa};
    step(1);
  endtask

  task automatic req(input op_e op, input dev_class_e cls, input logic disp, input logic used,
                     input logic drv, input logic [1:0] mem, input logic acc);
    @(posedge ref_clk);
    req_used_in_prog <= used;
    req_driven_by_prog <= drv;
    mem_in_cassette <= mem[1];
    cassette_protect <= mem[0];
    tool_cmd_model_inst.request(op, cls, disp, {12'h5a0, cls});
    #1;
    chk_bit("req_accept", acc, req_accept);
    chk_bit("req_reject", !acc, req_reject);
    if (op == OP_SET_SETTING) chk_bit("setting_wr", acc, setting_wr);
  endtask

  task automatic force_chk(input op_e op, input dev_class_e cls, input logic used,
                           input logic ret, input logic hold_after);
    req(op, cls, 1'b0, used, 1'b1, 2'b00, 1'b1);
    chk_bit("force_hold", 1'b1, force_hold);
    chk_bit("force_value", op == OP_FORCE_ON, force_value);
    chk_bit("force_retain", ret, force_retain);
    @(posedge ref_clk);
    scan_end <= 1'b1;
    @(posedge ref_clk);
    scan_end <= 1'b0;
    #1;
    chk_bit("force_hold after scan", hold_after, force_hold);
  endtask

  initial begin
    rst_n = 1'b0; clk_en = 1'b1; mode_switch_run = 1'b1; general_inputs = 16'h0000;
    run_input_en = 1'b1; run_input_sel = 4'hf; diag_hw_ok = 1'b1; diag_param_ok = 1'b1;
    diag_prog_ok = 1'b1; scan_end = 1'b0; req_used_in_prog = 1'b0; req_driven_by_prog = 1'b0;
    mem_in_cassette = 1'b0; cassette_protect = 1'b0; prog_wr = 1'b0; prog_data = 16'h0000;
    err_count = 0; n_compared = 0;
    power_up(1'b1, 1'b1, 1'b1);
    step(1000);
    chk_bit("run_active in diagnosis", 1'b0, run_active);
    wait_on(1'b0);
    chk_bit("run_led", 1'b1, run_led);
    $display("Test diagnosis pass done");
    for (int k = 0; k < 4; k++) begin
      set_local(k[1], k[0]);
      chk_bit("run_active local", k != 0, run_active);
    end
    pick_input(1'b1, 4'he);
    set_local(1'b0, 1'b1);
    chk_bit("run_active other input", 1'b0, run_active);
    pick_input(1'b0, 4'hf);
    set_local(1'b0, 1'b1);
    chk_bit("run_active undesignated", 1'b0, run_active);
    pick_input(1'b1, 4'hf);
    $display("Test local sources done");
    set_local(1'b1, 1'b0);
    tool_cmd_model_inst.command(1'b0);
    step(6);
    chk_bit("run_active tool stop", 1'b0, run_active);
    tool_cmd_model_inst.command(1'b1);
    #1;
    chk_bit("run_active tool run", 1'b1, run_active);
    tool_cmd_model_inst.command(1'b0);
    set_local(1'b0, 1'b0);
    chk_bit("run_active switch stop", 1'b0, run_active);
    set_local(1'b1, 1'b0);
    chk_bit("run_active switch run", 1'b1, run_active);
    tool_cmd_model_inst.command(1'b0);
    set_local(1'b0, 1'b0);
    set_local(1'b0, 1'b1);
    chk_bit("run_active input run", 1'b1, run_active);
    set_local(1'b0, 1'b0);
    tool_cmd_model_inst.command(1'b1);
    #1;
    chk_bit("run_active remote run", 1'b1, run_active);
    tool_cmd_model_inst.command(1'b0);
    #1;
    chk_bit("run_active remote stop", 1'b0, run_active);
    $display("Test tool override done");
    req(OP_FORCE_ON, CLS_INPUT, 1'b0, 1'b0, 1'b0, 2'b00, 1'b1);
    req(OP_FORCE_ON, CLS_INPUT, 1'b1, 1'b0, 1'b0, 2'b00, 1'b0);
    req(OP_FORCE_OFF, CLS_OUTPUT, 1'b1, 1'b0, 1'b0, 2'b00, 1'b1);
    req(OP_FORCE_ON, CLS_AUX, 1'b0, 1'b1, 1'b0, 2'b00, 1'b1);
    req(OP_FORCE_OFF, CLS_STATE, 1'b0, 1'b1, 1'b0, 2'b00, 1'b1);
    req(OP_FORCE_ON, CLS_COUNTER, 1'b0, 1'b1, 1'b0, 2'b00, 1'b1);
    req(OP_FORCE_ON, CLS_DATA, 1'b0, 1'b1, 1'b1, 2'b00, 1'b0);
    req(OP_FORCE_ON, CLS_TIMER, 1'b0, 1'b1, 1'b0, 2'b00, 1'b0);
    req(OP_FORCE_ON, CLS_TIMER, 1'b0, 1'b1, 1'b1, 2'b00, 1'b1);
    req(OP_FORCE_OFF, CLS_TIMER, 1'b0, 1'b1, 1'b0, 2'b00, 1'b1);
    req(OP_SET_CURRENT, CLS_EXT_FILE, 1'b0, 1'b0, 1'b0, 2'b00, 1'b0);
    req(OP_SET_CURRENT, CLS_EXT_FILE, 1'b1, 1'b0, 1'b0, 2'b00, 1'b1);
    req(OP_SET_CURRENT, CLS_FILE_PROG, 1'b1, 1'b0, 1'b0, 2'b00, 1'b0);
    req(OP_SET_CURRENT, CLS_FILE_PROG, 1'b0, 1'b0, 1'b0, 2'b00, 1'b1);
    req(OP_SET_SETTING, CLS_TIMER, 1'b0, 1'b1, 1'b1, 2'b00, 1'b1);
    req(OP_SET_SETTING, CLS_TIMER, 1'b0, 1'b1, 1'b1, 2'b11, 1'b0);
    req(OP_SET_SETTING, CLS_TIMER, 1'b0, 1'b1, 1'b1, 2'b10, 1'b1);
    req(OP_SET_SETTING, CLS_COUNTER, 1'b0, 1'b1, 1'b1, 2'b01, 1'b1);
    req(OP_SET_SETTING, CLS_COUNTER, 1'b0, 1'b1, 1'b0, 2'b00, 1'b0);
    req(OP_SET_SETTING, CLS_DATA, 1'b0, 1'b1, 1'b1, 2'b00, 1'b0);
    $display("Test request gating done");
    force_chk(OP_FORCE_ON, CLS_OUTPUT, 1'b1, 1'b1, 1'b1);
    force_chk(OP_FORCE_ON, CLS_INPUT, 1'b0, 1'b0, 1'b0);
    tool_cmd_model_inst.command(1'b1);
    force_chk(OP_FORCE_ON, CLS_OUTPUT, 1'b1, 1'b0, 1'b0);
    force_chk(OP_FORCE_OFF, CLS_AUX, 1'b0, 1'b1, 1'b1);
    $display("Test forcing done");
    req(OP_SET_CURRENT, CLS_DATA, 1'b0, 1'b1, 1'b1, 2'b00, 1'b1);
    chk_val("current_value tool", 16'h5a06, current_value);
    prog_write(16'h1234);
    #1;
    chk_val("current_value program", 16'h1234, current_value);
    fork
      req(OP_SET_CURRENT, CLS_DATA, 1'b0, 1'b1, 1'b1, 2'b00, 1'b1);
      begin
        step(1);
        prog_write(16'h4321);
      end
    join
    chk_val("current_value same cycle", 16'h5a06, current_value);
    // With the clock enable low, a program write and a tool stop must both be lost.
    for (int f = 0; f < 2; f++) begin
      @(posedge ref_clk);
      clk_en <= f[0];
      prog_write(16'h0f0f);
      tool_cmd_model_inst.command(1'b0);
      #1;
      chk_bit("run_active frozen", !f[0], run_active);
      chk_val("current_value frozen", f[0] ? 16'h0f0f : 16'h5a06, current_value);
    end
    $display("Test value writes done");
    set_local(1'b0, 1'b0);
    tool_cmd_model_inst.command(1'b1);
    power_up(1'b1, 1'b1, 1'b1);
    step(2010);
    chk_bit("run_active after power-up", 1'b0, run_active);
    set_local(1'b1, 1'b0);
    chk_bit("run_active switch after power-up", 1'b1, run_active);
    $display("Test override clear done");
    power_up(1'b0, 1'b1, 1'b1);
    wait_on(1'b1);
    chk_bit("run_active on fault", 1'b0, run_active);
    count_low();
    chk_bit("fault_led flashes", 1'b1, lows > 0);
    for (int j = 0; j < 2; j++) begin
      power_up(1'b1, j[0], !j[0]);
      wait_on(1'b1);
      count_low();
      chk_bit("fault_led steady", 1'b1, lows == 0);
    end
    $display("Test diagnosis faults done");
    final_report();
  end
endmodule
